// ==== rtl/pscd_cfg.svh ====
// Strap decoder constants: offsets, bit positions, resets, timing
`ifndef PSCD_CFG_SVH
`define PSCD_CFG_SVH
// Contract
// RULE_01: Hold low: pins give only starting values
// RULE_02: Hold high: pins force bits continuously
// RULE_03: Duplex pin shapes advertised full duplex
// RULE_04: Forced mode: duplex pin drives bit 0.8
// RULE_05: Speed pin rising edge restarts negotiation
// RULE_06: Forced mode: speed pin drives bit 0.13
// RULE_07: Board ties speed pin high for fiber
// RULE_08: Link-test pin shapes advertised speeds
// RULE_09: Forced mode: link-test pin drives 19.8
// RULE_10: Level pins supply five management address bits
// RULE_11: Middle levels set 0.12, 19.13, 19.3
// RULE_12: Level pin 2 middle sets symbol mode
// RULE_13: Forced mode: level pin 4 selects fiber
// RULE_14: Negotiation: pin 4 plus link-test set advertisement
// RULE_15: Hold select governs level pins alike
// RULE_16: Outer level, link-test low: advertise everything
// RULE_17: Synchronise straps, one restart per edge
`define PSCD_OFS_CTRL 8'h00
`define PSCD_OFS_ADV 8'h10
`define PSCD_OFS_MODE 8'h4C
`define PSCD_OFS_STAT 8'h50
`define PSCD_BIT_DUPLEX 8
`define PSCD_BIT_RESTART 9
`define PSCD_BIT_AN 12
`define PSCD_BIT_SPEED 13
`define PSCD_BIT_ADV_LO 5
`define PSCD_BIT_FIBER 2
`define PSCD_BIT_SCRAMBLE 3
`define PSCD_BIT_SYMBOL 4
`define PSCD_BIT_LINKTEST 8
`define PSCD_BIT_REPEATER 13
`define PSCD_RST_BIT 1'b0
`define PSCD_RST_ADV 4'h0
`define PSCD_RST_ADDR 5'h00
`define PSCD_SETTLE_CYCLES 2'h2
`define PSCD_RESP_OKAY 2'h0
`define PSCD_RESP_SLVERR 2'h2
`endif

// ==== rtl/pscd_pkg.sv ====
// Strap decoder types
package pscd_pkg;
  typedef enum logic [1:0] {
    level_bottom = 2'h0,
    level_lower_mid = 2'h1,
    level_upper_mid = 2'h2,
    level_top = 2'h3
  } pscd_level_t;

  typedef enum logic [2:0] {
    st_settle = 3'h1,
    st_load = 3'h2,
    st_run = 3'h4
  } pscd_state_t;

  typedef enum logic [2:0] {
    sel_ctrl,
    sel_adv,
    sel_mode,
    sel_stat,
    sel_none
  } pscd_sel_t;
endpackage

// ==== rtl/pscd_sync.sv ====
// Two-stage synchroniser for a vector of strap levels
module pscd_sync #(
  parameter int WIDTH = 14
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Levels
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '0;
      synced <= '0;
    end else begin
      stage1 <= raw;
      synced <= stage1;
    end
  end
endmodule

// ==== rtl/pscd_top.sv ====
// Strap decoder with AXI4-Lite view of the controlled bits
//
// The register addresses and register access over AXI4-Lite were decided locally.
`include "pscd_cfg.svh"
module pscd_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Strap pins
  input wire logic duplex_strap,
  input wire logic speed_strap,
  input wire logic link_test_strap,
  input wire logic strap_hold_select,
  input wire logic [1:0] multi_level_strap_0,
  input wire logic [1:0] multi_level_strap_1,
  input wire logic [1:0] multi_level_strap_2,
  input wire logic [1:0] multi_level_strap_3,
  input wire logic [1:0] multi_level_strap_4,
  // Decoded control bits
  output logic [4:0] phy_address,
  output logic duplex_full,
  output logic an_restart,
  output logic an_enable,
  output logic speed_100,
  output logic [3:0] adv_caps,
  output logic fiber_mode,
  output logic scrambler_bypass,
  output logic symbol_mode,
  output logic link_test_off,
  output logic repeater_mode,
  output logic config_done,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  function automatic logic is_mid(input logic [1:0] lvl);
    return (lvl == pscd_pkg::level_upper_mid) ||
           (lvl == pscd_pkg::level_lower_mid);
  endfunction

  function automatic pscd_pkg::pscd_sel_t decode(
    input logic [ADDR_W-1:0] addr);
    if (addr == ADDR_W'(`PSCD_OFS_CTRL)) begin
      return pscd_pkg::sel_ctrl;
    end else if (addr == ADDR_W'(`PSCD_OFS_ADV)) begin
      return pscd_pkg::sel_adv;
    end else if (addr == ADDR_W'(`PSCD_OFS_MODE)) begin
      return pscd_pkg::sel_mode;
    end else if (addr == ADDR_W'(`PSCD_OFS_STAT)) begin
      return pscd_pkg::sel_stat;
    end else begin
      return pscd_pkg::sel_none;
    end
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
    input logic [15:0] data, input logic [1:0] strb);
    return {strb[1] ? data[15:8] : old[15:8],
            strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // Returns bits 4.8, 4.7, 4.6, 4.5
  function automatic logic [3:0] adv_decode(input logic mid4,
    input logic lt, input logic fde);
    case ({mid4, lt})
      2'h0: return 4'hF;
      2'h1: return {2'h0, fde, 1'b1};
      2'h2: return {fde, 1'b1, 2'h0};
      default: return {fde, 1'b1, fde, 1'b1};
    endcase
  endfunction

  // Synchronised straps
  logic [13:0] raw_straps;
  logic [13:0] sync_q;
  logic duplex_s, speed_s, lt_s, hold_s;
  logic [1:0] ml0_s, ml1_s, ml2_s, ml3_s, ml4_s;

  assign raw_straps = {strap_hold_select, link_test_strap, speed_strap,
                       duplex_strap, multi_level_strap_4,
                       multi_level_strap_3, multi_level_strap_2,
                       multi_level_strap_1, multi_level_strap_0};

  pscd_sync #(.WIDTH(14)) u_sync ( // RULE_17
    .aclk(aclk),
    .aresetn(aresetn),
    .raw(raw_straps),
    .synced(sync_q)
  );

  assign {hold_s, lt_s, speed_s, duplex_s} = sync_q[13:10];
  assign {ml4_s, ml3_s, ml2_s, ml1_s, ml0_s} = sync_q[9:0];

  // Start-up sequencing
  pscd_pkg::pscd_state_t state;
  logic [1:0] settle_cnt;
  logic apply;
  logic speed_prev;
  logic restart_evt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= pscd_pkg::st_settle;
      settle_cnt <= 2'h0;
    end else begin
      case (state)
        pscd_pkg::st_settle: begin
          settle_cnt <= settle_cnt + 2'h1;
          if (settle_cnt == `PSCD_SETTLE_CYCLES) begin
            state <= pscd_pkg::st_load;
          end
        end
        pscd_pkg::st_load: state <= pscd_pkg::st_run;
        default: state <= pscd_pkg::st_run;
      endcase
    end
  end

  // Load once at start, or follow pins while hold is high
  assign apply = (state == pscd_pkg::st_load) ||
                 (hold_s && state == pscd_pkg::st_run); // RULE_01 RULE_02 RULE_15

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_prev <= `PSCD_RST_BIT;
    end else begin
      speed_prev <= speed_s;
    end
  end

  // Edge seen on synchronised samples only
  assign restart_evt = (state == pscd_pkg::st_run) && an_enable &&
                       speed_s && !speed_prev; // RULE_05 RULE_17

  // Write channel handling
  logic aw_full, w_full, aw_take, w_take, do_write;
  logic next_aw_full, next_w_full, next_bvalid;
  logic [ADDR_W-1:0] aw_addr_q, wr_addr;
  logic [15:0] w_data_q, wr_data;
  logic [1:0] w_strb_q, wr_strb;
  pscd_pkg::pscd_sel_t wr_sel;

  assign aw_take = s_axi_awready && s_axi_awvalid;
  assign w_take = s_axi_wready && s_axi_wvalid;
  assign do_write = (aw_full || aw_take) && (w_full || w_take);
  assign next_aw_full = !do_write && (aw_full || aw_take);
  assign next_w_full = !do_write && (w_full || w_take);
  assign next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
  assign wr_addr = aw_full ? aw_addr_q : s_axi_awaddr;
  assign wr_data = w_full ? w_data_q : s_axi_wdata[15:0];
  assign wr_strb = w_full ? w_strb_q : s_axi_wstrb[1:0];
  assign wr_sel = decode(wr_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PSCD_RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= 16'h0000;
      w_strb_q <= 2'h0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      s_axi_awready <= !next_aw_full && !next_bvalid;
      s_axi_wready <= !next_w_full && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata[15:0];
        w_strb_q <= s_axi_wstrb[1:0];
      end
      if (do_write) begin
        s_axi_bresp <= (wr_sel == pscd_pkg::sel_none) ?
                       `PSCD_RESP_SLVERR : `PSCD_RESP_OKAY;
      end
    end
  end

  // Register views and next values
  logic [15:0] ctrl_v, adv_v, mode_v, stat_v;
  logic [15:0] sw_ctrl, sw_adv, sw_mode;
  logic next_an, next_duplex, next_speed, next_restart;
  logic next_lt, next_rep, next_sym, next_scr, next_fib;
  logic [3:0] next_adv;
  logic [4:0] next_addr;
  logic wr_ctrl, wr_adv, wr_mode;

  always_comb begin
    ctrl_v = 16'h0000;
    ctrl_v[`PSCD_BIT_DUPLEX] = duplex_full;
    ctrl_v[`PSCD_BIT_RESTART] = an_restart;
    ctrl_v[`PSCD_BIT_AN] = an_enable;
    ctrl_v[`PSCD_BIT_SPEED] = speed_100;
    adv_v = 16'h0000;
    adv_v[`PSCD_BIT_ADV_LO +: 4] = adv_caps;
    mode_v = 16'h0000;
    mode_v[`PSCD_BIT_FIBER] = fiber_mode;
    mode_v[`PSCD_BIT_SCRAMBLE] = scrambler_bypass;
    mode_v[`PSCD_BIT_SYMBOL] = symbol_mode;
    mode_v[`PSCD_BIT_LINKTEST] = link_test_off;
    mode_v[`PSCD_BIT_REPEATER] = repeater_mode;
    stat_v = {5'h00, config_done, hold_s, lt_s, speed_s, duplex_s,
              1'b0, phy_address};
  end

  assign wr_ctrl = do_write && (wr_sel == pscd_pkg::sel_ctrl);
  assign wr_adv = do_write && (wr_sel == pscd_pkg::sel_adv);
  assign wr_mode = do_write && (wr_sel == pscd_pkg::sel_mode);
  assign sw_ctrl = wr_ctrl ? merge16(ctrl_v, wr_data, wr_strb) : ctrl_v;
  assign sw_adv = wr_adv ? merge16(adv_v, wr_data, wr_strb) : adv_v;
  assign sw_mode = wr_mode ? merge16(mode_v, wr_data, wr_strb) : mode_v;

  always_comb begin
    next_an = sw_ctrl[`PSCD_BIT_AN];
    next_duplex = sw_ctrl[`PSCD_BIT_DUPLEX];
    next_speed = sw_ctrl[`PSCD_BIT_SPEED];
    next_restart = sw_ctrl[`PSCD_BIT_RESTART];
    next_adv = sw_adv[`PSCD_BIT_ADV_LO +: 4];
    next_fib = sw_mode[`PSCD_BIT_FIBER];
    next_scr = sw_mode[`PSCD_BIT_SCRAMBLE];
    next_sym = sw_mode[`PSCD_BIT_SYMBOL];
    next_lt = sw_mode[`PSCD_BIT_LINKTEST];
    next_rep = sw_mode[`PSCD_BIT_REPEATER];
    next_addr = phy_address;
    if (apply) begin
      next_addr = {ml4_s[1], ml3_s[1], ml2_s[1], ml1_s[1], ml0_s[1]}; // RULE_10
      next_an = is_mid(ml0_s); // RULE_11
      next_rep = is_mid(ml1_s); // RULE_11
      next_scr = is_mid(ml3_s); // RULE_11
      next_sym = is_mid(ml2_s); // RULE_12
      if (next_an) begin
        next_adv = adv_decode(is_mid(ml4_s), lt_s, duplex_s); // RULE_03 RULE_08 RULE_14 RULE_16
      end else begin
        next_duplex = duplex_s; // RULE_04
        next_speed = speed_s; // RULE_06
        next_lt = lt_s; // RULE_09
        next_fib = is_mid(ml4_s); // RULE_13
      end
    end
    // Hardware set beats a software clear
    if (restart_evt) begin
      next_restart = 1'b1; // RULE_05
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phy_address <= `PSCD_RST_ADDR;
      an_enable <= `PSCD_RST_BIT;
      duplex_full <= `PSCD_RST_BIT;
      speed_100 <= `PSCD_RST_BIT;
      an_restart <= `PSCD_RST_BIT;
      adv_caps <= `PSCD_RST_ADV;
    end else begin
      phy_address <= next_addr;
      an_enable <= next_an;
      duplex_full <= next_duplex;
      speed_100 <= next_speed;
      an_restart <= next_restart;
      adv_caps <= next_adv;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fiber_mode <= `PSCD_RST_BIT;
      scrambler_bypass <= `PSCD_RST_BIT;
      symbol_mode <= `PSCD_RST_BIT;
      link_test_off <= `PSCD_RST_BIT;
      repeater_mode <= `PSCD_RST_BIT;
      config_done <= 1'b0;
    end else begin
      fiber_mode <= next_fib;
      scrambler_bypass <= next_scr;
      symbol_mode <= next_sym;
      link_test_off <= next_lt;
      repeater_mode <= next_rep;
      config_done <= (state != pscd_pkg::st_settle);
    end
  end

  // Read channel
  logic ar_take, next_rvalid;
  pscd_pkg::pscd_sel_t rd_sel;
  logic [15:0] rd_word;

  assign ar_take = s_axi_arready && s_axi_arvalid;
  assign next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);
  assign rd_sel = decode(s_axi_araddr);

  always_comb begin
    if (rd_sel == pscd_pkg::sel_ctrl) begin
      rd_word = ctrl_v;
    end else if (rd_sel == pscd_pkg::sel_adv) begin
      rd_word = adv_v;
    end else if (rd_sel == pscd_pkg::sel_mode) begin
      rd_word = mode_v;
    end else if (rd_sel == pscd_pkg::sel_stat) begin
      rd_word = stat_v;
    end else begin
      rd_word = 16'h0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PSCD_RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= {16'h0000, rd_word};
        s_axi_rresp <= (rd_sel == pscd_pkg::sel_none) ?
                       `PSCD_RESP_SLVERR : `PSCD_RESP_OKAY;
      end
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_speed_rise;
    $rose(speed_s) && state == pscd_pkg::st_run && an_enable;
  endsequence

  sequence s_boot;
    state == pscd_pkg::st_load ##1 state == pscd_pkg::st_run;
  endsequence

  a_sync_latency: assert property ( // RULE_17
    aresetn [*3] |-> sync_q == $past(raw_straps, 2))
    else $error("strap sync latency wrong");
  a_hold_idle: assert property ( // RULE_01
    (state == pscd_pkg::st_run && !hold_s && !wr_ctrl) |=>
    $stable(duplex_full) && $stable(speed_100) && $stable(an_enable))
    else $error("control bit moved without hold or write");
  a_hold_follow: assert property ( // RULE_02
    (hold_s && state == pscd_pkg::st_run && !is_mid(ml0_s)) [*2] |->
    speed_100 == $past(speed_s))
    else $error("held speed bit not following pin");
  a_duplex_forced: assert property ( // RULE_04
    (apply && !is_mid(ml0_s)) |=> duplex_full == $past(duplex_s))
    else $error("duplex bit not set from pin");
  a_restart_edge: assert property ( // RULE_05
    s_speed_rise |=> an_restart)
    else $error("restart not raised on speed edge");
  a_speed_forced: assert property ( // RULE_06
    (apply && !is_mid(ml0_s)) |=> speed_100 == $past(speed_s))
    else $error("speed bit not set from pin");
  a_linktest_forced: assert property ( // RULE_09
    (apply && !is_mid(ml0_s)) |=> link_test_off == $past(lt_s))
    else $error("link test bit not set from pin");
  a_addr_load: assert property ( // RULE_10
    apply |=> phy_address == $past({ml4_s[1], ml3_s[1], ml2_s[1],
                                    ml1_s[1], ml0_s[1]}))
    else $error("management address not taken from pins");
  a_mid_modes: assert property ( // RULE_11
    apply |=> an_enable == $past(is_mid(ml0_s)) &&
              repeater_mode == $past(is_mid(ml1_s)) &&
              scrambler_bypass == $past(is_mid(ml3_s)))
    else $error("middle level mode bits wrong");
  a_symbol_mode: assert property ( // RULE_12
    apply |=> symbol_mode == $past(is_mid(ml2_s)))
    else $error("symbol mode bit wrong");
  a_fiber_mode: assert property ( // RULE_13
    (apply && !is_mid(ml0_s)) |=> fiber_mode == $past(is_mid(ml4_s)))
    else $error("fiber select bit wrong");
  a_adv_both: assert property ( // RULE_14
    (apply && is_mid(ml0_s) && is_mid(ml4_s) && lt_s) |=>
    adv_caps == {$past(duplex_s), 1'b1, $past(duplex_s), 1'b1})
    else $error("10/100 advertisement wrong");
  a_boot_order: assert property ( // RULE_15
    s_boot |=> state == pscd_pkg::st_run && config_done)
    else $error("start-up load sequence wrong");
  a_adv_all: assert property ( // RULE_16
    (apply && is_mid(ml0_s) && !is_mid(ml4_s) && !lt_s) |=>
    adv_caps == 4'hF)
    else $error("full advertisement not set");
endmodule

// ==== dv/pscd_board.sv ====
// Board strap model: resistor ties and dividers on the strap pins
module pscd_board (
  // Chosen board settings
  input wire logic fiber_sel,
  input wire logic dup,
  input wire logic spd,
  input wire logic lt,
  input wire logic hold,
  input wire logic [9:0] lvl,
  // Strap pins
  output logic duplex_strap,
  output logic speed_strap,
  output logic link_test_strap,
  output logic strap_hold_select,
  output logic [9:0] levels
);
  timeunit 1ns;
  timeprecision 100ps;
  // Fiber boards tie the speed pin high
  assign speed_strap = fiber_sel | spd;
  assign duplex_strap = dup;
  assign link_test_strap = lt;
  assign strap_hold_select = hold;
  assign levels = lvl;
endmodule

// ==== dv/phy_strap_config_decode_tb.sv ====
// Self-checking bench for the strap decoder
module phy_strap_config_decode_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [9:0] l;
    logic d;
    logic s;
    logic t;
    logic [3:0] adv;
  } pscd_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic dup = 1'b0, spd = 1'b0, lt = 1'b0, hold = 1'b1, fib = 1'b0;
  logic [9:0] lvl = 10'h000;
  logic ds, ss, ls, hs;
  logic [9:0] lv;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [4:0] phy_address;
  logic [3:0] adv_caps;
  logic duplex_full, an_restart, an_enable, speed_100, fiber_mode;
  logic scrambler_bypass, symbol_mode, link_test_off, repeater_mode;
  logic config_done;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  pscd_row_t rows [10] = '{
    {10'h000, 3'h7, 4'h0}, {10'h2E7, 3'h0, 4'h0}, {10'h019, 3'h0, 4'hF},
    {10'h34E, 3'h5, 4'h3}, {10'h3B1, 3'h1, 4'h1}, {10'h1D6, 3'h4, 4'hC},
    {10'h201, 3'h0, 4'h4}, {10'h2AA, 3'h5, 4'hF}, {10'h1FD, 3'h3, 4'h5},
    {10'h100, 3'h5, 4'h0}};

  pscd_board u_board (.fiber_sel(fib), .dup(dup), .spd(spd), .lt(lt),
    .hold(hold), .lvl(lvl), .duplex_strap(ds), .speed_strap(ss),
    .link_test_strap(ls), .strap_hold_select(hs), .levels(lv));

  pscd_top u_dut (.aclk(aclk), .aresetn(aresetn), .duplex_strap(ds),
    .speed_strap(ss), .link_test_strap(ls), .strap_hold_select(hs),
    .multi_level_strap_0(lv[1:0]), .multi_level_strap_1(lv[3:2]),
    .multi_level_strap_2(lv[5:4]), .multi_level_strap_3(lv[7:6]),
    .multi_level_strap_4(lv[9:8]), .phy_address(phy_address),
    .duplex_full(duplex_full), .an_restart(an_restart),
    .an_enable(an_enable), .speed_100(speed_100), .adv_caps(adv_caps),
    .fiber_mode(fiber_mode), .scrambler_bypass(scrambler_bypass),
    .symbol_mode(symbol_mode), .link_test_off(link_test_off),
    .repeater_mode(repeater_mode), .config_done(config_done),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  task automatic finish_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic mid(input logic [1:0] c);
    return c[1] ^ c[0];
  endfunction

  // Wait n edges, then look between edges where outputs are settled
  task automatic settle(int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    logic ta, tw, tb, done;
    logic [1:0] r;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    chk("bresp", r, er);
  endtask

  task automatic axi_rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
    logic ta, done;
    logic [31:0] d;
    logic [1:0] r;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ta = arvalid & arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
    chk("rdata", d, ed);
    chk("rresp", r, er);
  endtask

  task automatic check_row(pscd_row_t r);
    chk("addr", phy_address, {r.l[9], r.l[7], r.l[5], r.l[3], r.l[1]});
    chk("an_en", an_enable, mid(r.l[1:0]));
    chk("repeat", repeater_mode, mid(r.l[3:2]));
    chk("symbol", symbol_mode, mid(r.l[5:4]));
    chk("scramble", scrambler_bypass, mid(r.l[7:6]));
    if (mid(r.l[1:0])) begin
      chk("adv", adv_caps, r.adv);
    end else begin
      chk("duplex", duplex_full, r.d);
      chk("speed", speed_100, r.s);
      chk("ltest", link_test_off, r.t);
      chk("fiber", fiber_mode, mid(r.l[9:8]));
    end
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    settle(8);
    foreach (rows[i]) begin
      @(posedge aclk);
      lvl <= rows[i].l;
      dup <= rows[i].d;
      spd <= rows[i].s;
      lt <= rows[i].t;
      settle(6);
      check_row(rows[i]);
    end
    // Restart on speed pin edge, cleared by software
    @(posedge aclk);
    lvl <= 10'h001;
    spd <= 1'b0;
    lt <= 1'b0;
    dup <= 1'b0;
    settle(6);
    axi_wr(8'h00, 32'h0000_1000, 2'h0);
    settle(2);
    chk("restart", an_restart, 1'b0);
    axi_rd(8'h10, 32'h0000_01E0, 2'h0);
    @(posedge aclk);
    spd <= 1'b1;
    settle(6);
    chk("restart", an_restart, 1'b1);
    axi_wr(8'h00, 32'h0000_1000, 2'h0);
    settle(6);
    chk("restart", an_restart, 1'b0);
    axi_rd(8'h50, 32'h0000_0680, 2'h0);
    axi_wr(8'h50, 32'hFFFF_FFFF, 2'h0);
    axi_rd(8'h04, 32'h0000_0000, 2'h2);
    axi_wr(8'h04, 32'hFFFF_FFFF, 2'h2);
    // Second reset with load-once straps
    @(posedge aclk);
    hold <= 1'b0;
    lvl <= 10'h107;
    dup <= 1'b1;
    spd <= 1'b0;
    lt <= 1'b1;
    aresetn <= 1'b0;
    settle(3);
    chk("addr", phy_address, 5'h00);
    chk("duplex", duplex_full, 1'b0);
    chk("done", config_done, 1'b0);
    @(posedge aclk);
    aresetn <= 1'b1;
    settle(10);
    chk("done", config_done, 1'b1);
    chk("addr", phy_address, 5'h01);
    chk("duplex", duplex_full, 1'b1);
    chk("fiber", fiber_mode, 1'b1);
    chk("ltest", link_test_off, 1'b1);
    chk("repeat", repeater_mode, 1'b1);
    axi_rd(8'h4C, 32'h0000_2104, 2'h0);
    @(posedge aclk);
    dup <= 1'b0;
    lvl <= 10'h103;
    settle(6);
    chk("duplex", duplex_full, 1'b1);
    chk("repeat", repeater_mode, 1'b1);
    axi_wr(8'h00, 32'h0000_0000, 2'h0);
    settle(1);
    chk("duplex", duplex_full, 1'b0);
    axi_rd(8'h00, 32'h0000_0000, 2'h0);
    @(posedge aclk);
    hold <= 1'b1;
    settle(6);
    chk("repeat", repeater_mode, 1'b0);
    axi_wr(8'h00, 32'h0000_0100, 2'h0);
    settle(2);
    chk("duplex", duplex_full, 1'b0);
    // Fiber board ties the speed pin high
    @(posedge aclk);
    fib <= 1'b1;
    settle(6);
    chk("speed", speed_100, 1'b1);
    finish_test();
  end
endmodule
